/* File: logic/rsi_pkg.sv */
package rsi_pkg;

    // ==========================================================
    // Reset values of the processor state
    localparam logic [31:0] PC_RESET    = 32'h0000_0000;
    localparam logic [31:0] ECR_RESET   = 32'h0000_0000;
    localparam logic [31:0] PSW_RESET   = 32'h0000_0020;
    localparam logic [31:0] PSW_SECURED = 32'h0000_0021;
    localparam logic [31:0] GPR_ZERO    = 32'h0000_0000;

    // ==========================================================
    // Memory map of the on-chip RAM and the boot scratch range
    localparam logic [31:0] RAM_BASE     = 32'h03ff_0000;
    localparam logic [31:0] SCRATCH_BASE = 32'h03ff_0000;
    localparam logic [31:0] SCRATCH_LAST = 32'h03ff_07ff;
    localparam int SCRATCH_WORDS      = int'((SCRATCH_LAST - SCRATCH_BASE + 32'h1) >> 2);
    localparam int SCRATCH_FIRST_WORD = int'((SCRATCH_BASE - RAM_BASE) >> 2);
    // Pattern the boot firmware leaves behind in its scratch words
    localparam logic [31:0] BOOT_FILL = 32'h5a5a_a5a5;

    // ==========================================================
    // Timing: a write seen this many cycles before a synchronised
    // external reset edge counts as still in flight
    localparam int WRITE_INFLIGHT_CYCLES = 4;

    // ==========================================================
    // Boot sequencer states
    typedef enum logic [1:0] {
        ST_HOLD,
        ST_SCRATCH,
        ST_VECTOR,
        ST_RUN
    } rsi_boot_state_t;

endpackage

/* File: logic/rsi_sync3.sv */
`timescale 1ns/100ps
// ==========================================================
// Three-stage synchroniser with agreement filter
// The output only follows once stages two and three agree; stage one
// feeds stage two alone. An asynchronous set forces every stage high,
// which makes the same module usable as a reset-release synchroniser.
module rsi_sync3 (
    // Clock and resets
    input  wire logic clk,
    input  wire logic asyncSet,
    input  wire logic srst,
    // Data
    input  wire logic din,
    output logic      dout
);

    logic stage1Reg;
    logic stage2Reg;
    logic stage3Reg;
    logic outReg;

    // ==========================================================
    // Stages; idle level is high for both uses in this block
    always_ff @(posedge clk or posedge asyncSet) begin
        if (asyncSet) begin
            stage1Reg <= 1'b1;
            stage2Reg <= 1'b1;
            stage3Reg <= 1'b1;
            outReg    <= 1'b1;
        end else if (srst) begin
            stage1Reg <= 1'b1;
            stage2Reg <= 1'b1;
            stage3Reg <= 1'b1;
            outReg    <= 1'b1;
        end else begin
            stage1Reg <= din;
            stage2Reg <= stage1Reg;
            stage3Reg <= stage2Reg;
            if (stage2Reg == stage3Reg) begin
                outReg <= stage3Reg;
            end
        end
    end

    assign dout = outReg;

endmodule

/* File: logic/rsi_ram_block.sv */
`timescale 1ns/100ps
// ==========================================================
// One RAM block: single write port, registered read
// No reset at all, so contents survive every reset source.
module rsi_ram_block #(
    parameter int WORDS  = 512,
    parameter int DATA_W = 32
) (
    // Clock
    input  wire logic                     clk,
    // Write port
    input  wire logic                     wrEn,
    input  wire logic [$clog2(WORDS)-1:0] wrAddr,
    input  wire logic [DATA_W-1:0]        wrData,
    // Read port
    input  wire logic [$clog2(WORDS)-1:0] rdAddr,
    output logic      [DATA_W-1:0]        rdData
);

    logic [DATA_W-1:0] memArray [WORDS];
    logic [DATA_W-1:0] rdDataReg;

    // ==========================================================
    // Storage and registered read
    always_ff @(posedge clk) begin
        if (wrEn) begin
            memArray[wrAddr] <= wrData;
        end
        rdDataReg <= memArray[rdAddr];
    end

    assign rdData = rdDataReg;

endmodule

/* File: logic/rsi_reset_init.sv */
`timescale 1ns/100ps
// Overview of operation
// - Every reset source acts on the state at once, without waiting for a clock edge.
// - Any reset source puts the processor state in its reset state; only power-on resets the RAM undefined flags.
// - After release a boot sequence runs before the user program, changing some state.
// - The program counter resets to zero, then the boot loads the programmed start address.
// - The exception cause register reads zero after reset and at user start.
// - The status word resets to 0x20.
// - At user start the status word is 0x20 unless a security flag or start address is set.
// - General registers 1 to 31 are not reset; register 0 reads zero.
// - After power-on every RAM block counts as undefined.
// - A reset during a write may spoil only the block being written.
// - The falling external reset is what spoils a write in flight.
// - Internal resets leave RAM contents outside the boot scratch range untouched.
// - The boot scratch range is undefined at user start; other RAM keeps its state.
module rsi_reset_init #(
    parameter int RAM_BLOCKS  = 4,
    parameter int BLOCK_WORDS = 512
) (
    // Clock and housekeeping reset
    input  wire logic                 ref_clk,
    input  wire logic                 srst,
    // Reset sources, asynchronous
    input  wire logic                 extResetN,
    input  wire logic                 pocReset,
    input  wire logic                 wdtReset,
    input  wire logic                 clkMonReset,
    input  wire logic                 swReset,
    // Boot configuration from the nonvolatile extra area
    input  wire logic [31:0]          resetVector,
    input  wire logic                 vectorSet,
    input  wire logic                 securitySet,
    // Processor state
    output logic      [31:0]          programCounter,
    output logic      [31:0]          processorStatusWord,
    output logic      [31:0]          exceptionCauseReg,
    output logic                      cpuInReset,
    output logic                      userRunning,
    // General registers
    input  wire logic                 gprWrEn,
    input  wire logic [4:0]           gprWrIdx,
    input  wire logic [31:0]          gprWrData,
    input  wire logic [4:0]           gprRdIdx,
    output logic      [31:0]          gprRdData,
    // RAM port, word address relative to the RAM base
    input  wire logic                 ramWrEn,
    input  wire logic [$clog2(RAM_BLOCKS*BLOCK_WORDS)-1:0] ramWordAddr,
    input  wire logic [31:0]          ramWrData,
    output logic      [31:0]          ramRdData,
    output logic      [RAM_BLOCKS-1:0] ramBlockUndef
);

    localparam int LOC_W = $clog2(BLOCK_WORDS);
    localparam int BLK_W = (RAM_BLOCKS > 1) ? $clog2(RAM_BLOCKS) : 1;
    localparam int ADR_W = $clog2(RAM_BLOCKS * BLOCK_WORDS);
    localparam int CNT_W = $clog2(rsi_pkg::SCRATCH_WORDS);
    localparam int AGE_W = 3;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(rsi_pkg::SCRATCH_WORDS - 1);
    localparam logic [ADR_W-1:0] SCR_FIRST = ADR_W'(rsi_pkg::SCRATCH_FIRST_WORD);
    localparam logic [AGE_W-1:0] AGE_LIMIT = AGE_W'(rsi_pkg::WRITE_INFLIGHT_CYCLES);
    localparam int SCR_BLOCK = rsi_pkg::SCRATCH_FIRST_WORD / BLOCK_WORDS;

    // ==========================================================
    // Reset combining
    // The pin already passes an analog filter, so the plain OR is safe
    // to use as an asynchronous reset without clock involvement.
    wire sysResetAsync = pocReset | ~extResetN | wdtReset | clkMonReset | swReset;
    wire releaseHeld;
    wire extLevel;

    rsi_sync3 u_releaseSync (
        .clk      (ref_clk),
        .asyncSet (sysResetAsync),
        .srst     (srst),
        .din      (1'b0),
        .dout     (releaseHeld)
    );

    rsi_sync3 u_extSync (
        .clk      (ref_clk),
        .asyncSet (1'b0),
        .srst     (srst),
        .din      (extResetN),
        .dout     (extLevel)
    );

    // ==========================================================
    // Boot sequencer
    rsi_pkg::rsi_boot_state_t stateReg, stateNext;
    logic [31:0]      pcReg, pcNext;
    logic [31:0]      pswReg, pswNext;
    logic [CNT_W-1:0] cntReg, cntNext;

    wire bootWr     = (stateReg == rsi_pkg::ST_SCRATCH);
    wire customBoot = vectorSet | securitySet;
    wire running    = (stateReg == rsi_pkg::ST_RUN);

    // Next-state decode
    always_comb begin
        stateNext = stateReg;
        pcNext    = pcReg;
        pswNext   = pswReg;
        cntNext   = cntReg;
        case (stateReg)
            rsi_pkg::ST_HOLD: begin
                if (!releaseHeld) begin
                    stateNext = rsi_pkg::ST_SCRATCH;
                end
            end
            rsi_pkg::ST_SCRATCH: begin
                cntNext = cntReg + CNT_W'(1);
                if (cntReg == CNT_LAST) begin
                    stateNext = rsi_pkg::ST_VECTOR;
                end
            end
            rsi_pkg::ST_VECTOR: begin
                pcNext    = vectorSet ? resetVector : rsi_pkg::PC_RESET;
                pswNext   = customBoot ? rsi_pkg::PSW_SECURED : rsi_pkg::PSW_RESET;
                stateNext = rsi_pkg::ST_RUN;
            end
            rsi_pkg::ST_RUN: begin
                stateNext = rsi_pkg::ST_RUN;
            end
            default: begin
                stateNext = rsi_pkg::ST_HOLD;
            end
        endcase
    end

    // State registers, cleared by any reset source without a clock
    always_ff @(posedge ref_clk or posedge sysResetAsync) begin
        if (sysResetAsync) begin
            stateReg <= rsi_pkg::ST_HOLD;
            pcReg    <= rsi_pkg::PC_RESET;
            pswReg   <= rsi_pkg::PSW_RESET;
            cntReg   <= '0;
        end else if (srst) begin
            stateReg <= rsi_pkg::ST_HOLD;
            pcReg    <= rsi_pkg::PC_RESET;
            pswReg   <= rsi_pkg::PSW_RESET;
            cntReg   <= '0;
        end else begin
            stateReg <= stateNext;
            pcReg    <= pcNext;
            pswReg   <= pswNext;
            cntReg   <= cntNext;
        end
    end

    assign programCounter      = pcReg;
    assign processorStatusWord = pswReg;
    assign exceptionCauseReg   = rsi_pkg::ECR_RESET;
    assign cpuInReset          = ~running;
    assign userRunning         = running;

    // ==========================================================
    // General registers: no reset, so contents are whatever they were
    logic [31:0] gprFile [1:31];
    logic [31:0] gprRdReg;

    wire gprWrOk = gprWrEn & running & (gprWrIdx != 5'h0);

    always_ff @(posedge ref_clk) begin
        if (gprWrOk) begin
            gprFile[gprWrIdx] <= gprWrData;
        end
    end

    // Register zero is hard-wired, never stored
    always_ff @(posedge ref_clk or posedge sysResetAsync) begin
        if (sysResetAsync) begin
            gprRdReg <= rsi_pkg::GPR_ZERO;
        end else if (gprRdIdx == 5'h0) begin
            gprRdReg <= rsi_pkg::GPR_ZERO;
        end else begin
            gprRdReg <= gprFile[gprRdIdx];
        end
    end

    assign gprRdData = gprRdReg;

    // ==========================================================
    // RAM port muxing: the boot sequence owns the port while it runs
    wire              userWr  = ramWrEn & running;
    wire [ADR_W-1:0]  bootAdr = SCR_FIRST + ADR_W'(cntReg);
    wire [ADR_W-1:0]  ramAdr  = bootWr ? bootAdr : ramWordAddr;
    wire [31:0]       ramDin  = bootWr ? rsi_pkg::BOOT_FILL : ramWrData;
    wire              anyWr   = bootWr | userWr;
    wire [BLK_W-1:0]  adrBlk  = BLK_W'(ramAdr >> LOC_W);
    wire [LOC_W-1:0]  adrLoc  = ramAdr[LOC_W-1:0];

    // ==========================================================
    // Write-in-flight tracking across an external reset
    // These flops ignore the reset sources on purpose: they must still
    // know which block was being written when the pin fell.
    logic [AGE_W-1:0] wrAgeReg;
    logic [BLK_W-1:0] lastBlkReg;
    logic             extLevelPrevReg;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wrAgeReg        <= '1;
            lastBlkReg      <= '0;
            extLevelPrevReg <= 1'b1;
        end else begin
            extLevelPrevReg <= extLevel;
            if (userWr) begin
                wrAgeReg   <= '0;
                lastBlkReg <= adrBlk;
            end else if (wrAgeReg != '1) begin
                wrAgeReg <= wrAgeReg + AGE_W'(1);
            end
        end
    end

    // Only the falling pin spoils a write; internal resets never do
    wire extFall    = extLevelPrevReg & ~extLevel;
    wire corruptEvt = extFall & (wrAgeReg <= AGE_LIMIT);

    // ==========================================================
    // RAM blocks and their undefined flags
    logic [31:0]      blkRd [RAM_BLOCKS];
    logic [BLK_W-1:0] rdBlkReg;
    logic [RAM_BLOCKS-1:0] undefReg;

    genvar b;
    generate
        for (b = 0; b < RAM_BLOCKS; b++) begin : g_blk
            wire selB   = (adrBlk == BLK_W'(b));
            wire setB   = (corruptEvt & (lastBlkReg == BLK_W'(b))) | (bootWr & selB);
            wire clearB = userWr & selB;

            rsi_ram_block #(
                .WORDS  (BLOCK_WORDS),
                .DATA_W (32)
            ) u_ram (
                .clk    (ref_clk),
                .wrEn   (anyWr & selB),
                .wrAddr (adrLoc),
                .wrData (ramDin),
                .rdAddr (adrLoc),
                .rdData (blkRd[b])
            );

            // Set wins over the clearing write; power-on marks all
            always_ff @(posedge ref_clk or posedge pocReset) begin
                if (pocReset) begin
                    undefReg[b] <= 1'b1;
                end else if (srst) begin
                    undefReg[b] <= 1'b1;
                end else if (setB) begin
                    undefReg[b] <= 1'b1;
                end else if (clearB) begin
                    undefReg[b] <= 1'b0;
                end
            end
        end
    endgenerate

    // Read block select is registered on the same edge as the block read data
    always_ff @(posedge ref_clk) begin
        rdBlkReg <= adrBlk;
    end

    assign ramRdData     = blkRd[rdBlkReg];
    assign ramBlockUndef = undefReg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst || sysResetAsync);

    property p_pc_zero_boot;
        (stateReg != rsi_pkg::ST_RUN) |-> (pcReg == rsi_pkg::PC_RESET);
    endproperty
    a_pc_zero_boot: assert property (p_pc_zero_boot)
        else $error("pc not zero before user start");

    property p_pc_vector;
        (stateReg == rsi_pkg::ST_VECTOR) |=>
            (pcReg == ($past(vectorSet) ? $past(resetVector) : rsi_pkg::PC_RESET));
    endproperty
    a_pc_vector: assert property (p_pc_vector)
        else $error("pc not loaded from start address");

    property p_ecr_zero;
        $rose(running) |-> (exceptionCauseReg == rsi_pkg::ECR_RESET);
    endproperty
    a_ecr_zero: assert property (p_ecr_zero)
        else $error("cause register nonzero at user start");

    property p_psw_boot;
        (stateReg != rsi_pkg::ST_RUN) |-> (pswReg == rsi_pkg::PSW_RESET);
    endproperty
    a_psw_boot: assert property (p_psw_boot)
        else $error("status word not 0x20 during boot");

    property p_psw_user;
        $rose(running) |->
            (pswReg == ($past(customBoot) ? rsi_pkg::PSW_SECURED : rsi_pkg::PSW_RESET));
    endproperty
    a_psw_user: assert property (p_psw_user)
        else $error("status word wrong at user start");

    property p_r0_zero;
        (gprRdIdx == 5'h0) |=> (gprRdData == rsi_pkg::GPR_ZERO);
    endproperty
    a_r0_zero: assert property (p_r0_zero)
        else $error("register zero read nonzero");

    property p_scratch_len;
        (bootWr && cntReg == CNT_LAST) |=> (stateReg == rsi_pkg::ST_VECTOR) ##1 running;
    endproperty
    a_scratch_len: assert property (p_scratch_len)
        else $error("boot sequence length wrong");

    property p_scratch_undef;
        $rose(running) |-> undefReg[SCR_BLOCK];
    endproperty
    a_scratch_undef: assert property (p_scratch_undef)
        else $error("scratch block not undefined at user start");

    // Own disable: the spoil event lands while the pin is usually still low,
    // so the shared disable on the reset sources would hide it completely
    property p_corrupt_only_one;
        disable iff (srst || pocReset)
        corruptEvt |=> (undefReg == ($past(undefReg) | (RAM_BLOCKS'(1) << $past(lastBlkReg))));
    endproperty
    a_corrupt_only_one: assert property (p_corrupt_only_one)
        else $error("reset during write touched wrong blocks");

    c_boot_plain:  cover property ($rose(running) && pswReg == rsi_pkg::PSW_RESET);
    c_boot_custom: cover property ($rose(running) && pswReg == rsi_pkg::PSW_SECURED);
    c_corrupt:     cover property (disable iff (srst || pocReset) corruptEvt);
    c_user_write:  cover property (userWr ##1 gprWrOk);

endmodule

/* File: tb/tb_reset_state_initialization.sv */
`timescale 1ns/100ps
module tb_reset_state_initialization;
    localparam int NBLK   = 4;
    localparam int BWORDS = 512;
    localparam int AW     = $clog2(NBLK*BWORDS);

    // ==========================================================
    // Clock, reset and stimulus
    logic          ref_clk     = 1'b0;
    logic          srst        = 1'b1;
    logic          extResetN   = 1'b1;
    logic          pocReset    = 1'b0;
    logic          wdtReset    = 1'b0;
    logic          clkMonReset = 1'b0;
    logic          swReset     = 1'b0;
    logic [31:0]   resetVector = 32'h0000_4000;
    logic          vectorSet   = 1'b0;
    logic          securitySet = 1'b0;
    logic          gprWrEn     = 1'b0;
    logic [4:0]    gprWrIdx    = 5'h00;
    logic [31:0]   gprWrData   = 32'h0000_0000;
    logic [4:0]    gprRdIdx    = 5'h00;
    logic          ramWrEn     = 1'b0;
    logic [AW-1:0] ramWordAddr = '0;
    logic [31:0]   ramWrData   = 32'h0000_0000;
    logic [31:0]   programCounter;
    logic [31:0]   processorStatusWord;
    logic [31:0]   exceptionCauseReg;
    logic          cpuInReset;
    logic          userRunning;
    logic [31:0]   gprRdData;
    logic [31:0]   ramRdData;
    logic [NBLK-1:0] ramBlockUndef;
    int            mismatches = 0;
    int            checks     = 0;

    always #2.5 ref_clk = ~ref_clk;

    rsi_reset_init #(.RAM_BLOCKS(NBLK), .BLOCK_WORDS(BWORDS)) dut (
        .ref_clk(ref_clk), .srst(srst), .extResetN(extResetN), .pocReset(pocReset),
        .wdtReset(wdtReset), .clkMonReset(clkMonReset), .swReset(swReset),
        .resetVector(resetVector), .vectorSet(vectorSet), .securitySet(securitySet),
        .programCounter(programCounter), .processorStatusWord(processorStatusWord),
        .exceptionCauseReg(exceptionCauseReg), .cpuInReset(cpuInReset),
        .userRunning(userRunning), .gprWrEn(gprWrEn), .gprWrIdx(gprWrIdx),
        .gprWrData(gprWrData), .gprRdIdx(gprRdIdx), .gprRdData(gprRdData),
        .ramWrEn(ramWrEn), .ramWordAddr(ramWordAddr), .ramWrData(ramWrData),
        .ramRdData(ramRdData), .ramBlockUndef(ramBlockUndef)
    );

    // ==========================================================
    // Shared helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("Counts: %0d checks, %0d mismatches", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Bounded wait for the boot sequence to hand over to the user program
    task automatic wait_run;
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (userRunning !== 1'b1 && n < 700);
        chk({31'h0, userRunning}, 32'h1, "boot did not reach user start");
    endtask

    function automatic logic [AW-1:0] waddr(input int blk, input int word);
        return AW'({blk[1:0], word[8:0]});
    endfunction

    // Ends by lowering the strobe, so the next call always waits a fresh edge
    task automatic ram_wr(input int blk, input int word, input logic [31:0] data);
        @(posedge ref_clk);
        ramWrEn     <= 1'b1;
        ramWordAddr <= waddr(blk, word);
        ramWrData   <= data;
        @(posedge ref_clk);
        ramWrEn     <= 1'b0;
    endtask

    task automatic ram_chk(input int blk, input int word, input logic [31:0] exp);
        @(posedge ref_clk);
        ramWordAddr <= waddr(blk, word);
        repeat (2) @(posedge ref_clk);
        #1;
        chk(ramRdData, exp, "RAM word changed");
    endtask

    task automatic gpr_chk(input logic [4:0] idx, input logic [31:0] wd, input logic [31:0] exp);
        @(posedge ref_clk);
        gprWrEn   <= 1'b1;
        gprWrIdx  <= idx;
        gprWrData <= wd;
        gprRdIdx  <= idx;
        @(posedge ref_clk);
        gprWrEn   <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk(gprRdData, exp, "general register read");
    endtask

    // Asserts one source for 4 cycles; the state must flip before any clock edge
    task automatic pulse_src(input int which);
        @(posedge ref_clk);
        case (which)
            0: pocReset <= 1'b1;
            1: extResetN <= 1'b0;
            2: wdtReset <= 1'b1;
            3: clkMonReset <= 1'b1;
            default: swReset <= 1'b1;
        endcase
        #1;
        chk({31'h0, cpuInReset}, 32'h1, "reset not taken at once");
        chk(programCounter, 32'h0000_0000, "pc during reset");
        chk(processorStatusWord, 32'h0000_0020, "status during reset");
        chk(exceptionCauseReg, 32'h0000_0000, "cause during reset");
        repeat (4) @(posedge ref_clk);
        pocReset    <= 1'b0;
        extResetN   <= 1'b1;
        wdtReset    <= 1'b0;
        clkMonReset <= 1'b0;
        swReset     <= 1'b0;
        wait_run();
    endtask

    // ==========================================================
    // Scenarios
    task automatic test_power_up;
        wait_run();
        chk(32'(ramBlockUndef), 32'h0000_000f, "all blocks undefined");
        chk(processorStatusWord, 32'h0000_0020, "plain start status");
        chk(exceptionCauseReg, 32'h0000_0000, "cause at start");
        gpr_chk(5'h00, 32'hffff_ffff, 32'h0000_0000);
        gpr_chk(5'h07, 32'h1234_5678, 32'h1234_5678);
        $display("test power_up finished");
    endtask

    // Internal sources must leave RAM alone; only the scratch block is spoiled
    task automatic test_internal_keep;
        @(posedge ref_clk);
        vectorSet <= 1'b1;
        for (int b = 1; b < NBLK; b++) ram_wr(b, 9, 32'hc0de_0000 + 32'(b));
        #1;
        chk(32'(ramBlockUndef), 32'h0000_0001, "user writes clear flags");
        for (int s = 2; s <= 4; s++) begin
            pulse_src(s);
            chk(programCounter, 32'h0000_4000, "start address");
            chk(processorStatusWord, 32'h0000_0021, "status with vector");
            chk(exceptionCauseReg, 32'h0000_0000, "cause at start");
            chk(32'(ramBlockUndef), 32'h0000_0001, "flags after internal");
            for (int b = 1; b < NBLK; b++) ram_chk(b, 9, 32'hc0de_0000 + 32'(b));
        end
        @(posedge ref_clk);
        vectorSet   <= 1'b0;
        securitySet <= 1'b1;
        pulse_src(4);
        chk(processorStatusWord, 32'h0000_0021, "status with security");
        @(posedge ref_clk);
        securitySet <= 1'b0;
        pulse_src(3);
        chk(processorStatusWord, 32'h0000_0020, "status plain again");
        chk(programCounter, 32'h0000_0000, "plain start address");
        $display("test internal_keep finished");
    endtask

    // A falling external reset spoils only a block with a write in flight
    task automatic test_ext_corrupt;
        for (int b = 1; b < NBLK; b++) ram_wr(b, 3, 32'hbeef_0000 + 32'(b));
        repeat (10) @(posedge ref_clk);
        pulse_src(1);
        chk(32'(ramBlockUndef), 32'h0000_0001, "idle external reset");
        ram_chk(2, 3, 32'hbeef_0002);
        @(posedge ref_clk);
        ramWrEn     <= 1'b1;
        ramWordAddr <= waddr(2, 5);
        ramWrData   <= 32'h7777_0002;
        @(posedge ref_clk);
        ramWrEn     <= 1'b0;
        extResetN   <= 1'b0;
        repeat (6) @(posedge ref_clk);
        extResetN   <= 1'b1;
        wait_run();
        chk(32'(ramBlockUndef), 32'h0000_0005, "only written block spoiled");
        ram_chk(1, 3, 32'hbeef_0001);
        ram_chk(3, 3, 32'hbeef_0003);
        $display("test ext_corrupt finished");
    endtask

    // Writes during boot are ignored; power-on marks every block undefined
    task automatic test_boot_and_poc;
        ram_wr(2, 5, 32'h5555_0002);
        @(posedge ref_clk);
        wdtReset <= 1'b1;
        repeat (3) @(posedge ref_clk);
        wdtReset <= 1'b0;
        ram_wr(3, 3, 32'hdead_dead);
        wait_run();
        ram_chk(3, 3, 32'hbeef_0003);
        chk(32'(ramBlockUndef), 32'h0000_0001, "boot write refused");
        pulse_src(0);
        chk(32'(ramBlockUndef), 32'h0000_000f, "power-on flags");
        gpr_chk(5'h00, 32'h0000_0001, 32'h0000_0000);
        $display("test boot_and_poc finished");
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        test_power_up();
        test_internal_keep();
        test_ext_corrupt();
        test_boot_and_poc();
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        $display("ERROR at %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule
